// >>> sr_gate_pkg.sv
// constants for the rectifier gate timing block
// assumes a single 100 MHz core clock; all times are converted here
package sr_gate_pkg;

	// =========================================================
	// clock and widths
	localparam int CLK_PERIOD_NS = 10;
	localparam int CNT_W         = 12;
	localparam int RATIO_W       = 7;
	localparam int TRIM_W        = 8;
	localparam int DLY_W         = 5;
	localparam int SENSE_N       = 5;

	// =========================================================
	// times as specified, and their cycle counts
	localparam int MAX_ON_US      = 40;
	localparam int MAX_ON_CYC     = (MAX_ON_US * 1000) / CLK_PERIOD_NS;
	localparam int SUBH_STEP_NS   = 500;
	localparam int SUBH_STEP_CYC  =
		(SUBH_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DEAD_TARGET_NS = 800;
	localparam int DEAD_TARGET_CYC = DEAD_TARGET_NS / CLK_PERIOD_NS;
	localparam int FAST_ON_NS     = 70;
	localparam int FAST_ON_CYC    =
		(FAST_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SLOW_ON_NS     = 200;
	localparam int SLOW_ON_CYC    =
		(SLOW_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// =========================================================
	// prediction ratios in percent, and the trim step in cycles
	localparam int RATIO_NORM = 66;
	localparam int RATIO_SUB  = 15;
	localparam int RATIO_STEP = 5;
	localparam int PERCENT    = 100;
	localparam int TRIM_STEP  = 1;

	// =========================================================
	// sense bit positions
	localparam int S_WAKE     = 0;
	localparam int S_LOCKOUT  = 1;
	localparam int S_DRN_LOW  = 2;
	localparam int S_DRN_OFF  = 3;
	localparam int S_PRI_ON   = 4;

	// gray coded along lockout->idle->delay->on->blank
	typedef enum logic [2:0] {
		ST_LOCKOUT = 3'h0,
		ST_IDLE    = 3'h1,
		ST_DELAY   = 3'h3,
		ST_ON      = 3'h2,
		ST_BLANK   = 3'h6
	} gate_state_t;

endpackage

// >>> sense_if.sv
// synchronised comparator levels passed from synchroniser to core
// assumes both ends run on the same core clock
`timescale 1ns/1ns
interface sense_if;
	logic supply_wake_level;
	logic supply_lockout_level;
	logic drain_low;
	logic drain_off;
	logic primary_on;

	modport producer (
		output supply_wake_level,
		output supply_lockout_level,
		output drain_low,
		output drain_off,
		output primary_on
	);
	modport consumer (
		input supply_wake_level,
		input supply_lockout_level,
		input drain_low,
		input drain_off,
		input primary_on
	);
endinterface

// >>> sense_sync.sv
// two-flop synchronisers for the asynchronous comparator inputs
// assumes raw inputs may change at any time relative to ref_clk
`timescale 1ns/1ns
module sense_sync #(
	parameter int N = sr_gate_pkg::SENSE_N
) (
	// clock and reset
	input  wire logic         ref_clk,
	input  wire logic         reset,
	// raw comparator levels
	input  wire logic [N-1:0] raw,
	// synchronised levels
	sense_if.producer         sense
);
	typedef struct packed {
		logic [N-1:0] stage1;
		logic [N-1:0] stage2;
	} sync_state_t;

	sync_state_t s;
	sync_state_t next_s;

	// =========================================================
	// first stage only feeds the second
	always_comb begin
		next_s        = s;
		next_s.stage1 = raw;
		next_s.stage2 = s.stage1;
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign sense.supply_wake_level    = s.stage2[sr_gate_pkg::S_WAKE];
	assign sense.supply_lockout_level = s.stage2[sr_gate_pkg::S_LOCKOUT];
	assign sense.drain_low            = s.stage2[sr_gate_pkg::S_DRN_LOW];
	assign sense.drain_off            = s.stage2[sr_gate_pkg::S_DRN_OFF];
	assign sense.primary_on           = s.stage2[sr_gate_pkg::S_PRI_ON];
endmodule

// >>> sr_gate_ctrl.sv
// rectifier_switch gate timing: lockout, threshold on/off, ccm prediction
// assumes comparator outputs arrive asynchronously; one core clock
`timescale 1ns/1ns
module sr_gate_ctrl #(
	parameter int MAX_ON  = sr_gate_pkg::MAX_ON_CYC,
	parameter int DLY_FST = sr_gate_pkg::FAST_ON_CYC,
	parameter int DLY_SLW = sr_gate_pkg::SLOW_ON_CYC
) (
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic reset,
	// supply comparators
	input  wire logic supply_wake_level,
	input  wire logic supply_lockout_level,
	// drain comparators
	input  wire logic turn_on_threshold,
	input  wire logic turn_off_threshold,
	input  wire logic primary_on,
	// line and load indication: high selects the slow turn-on delay
	input  wire logic slow_delay_sel,
	// gate drive and sub-harmonic flag
	output logic      rectifier_switch,
	output logic      sub_harmonic
);
	localparam int CW = sr_gate_pkg::CNT_W;
	localparam int RW = sr_gate_pkg::RATIO_W;
	localparam int TW = sr_gate_pkg::TRIM_W;
	localparam int DW = sr_gate_pkg::DLY_W;
	localparam int PW = CW + RW + 1;

	localparam logic [CW-1:0] CNT_MAX  = '1;
	localparam logic [CW-1:0] ON_LIM   = CW'(MAX_ON - 1);
	localparam logic [CW-1:0] SUBH     = CW'(sr_gate_pkg::SUBH_STEP_CYC);
	localparam logic [TW-1:0] DEAD_TGT = TW'(sr_gate_pkg::DEAD_TARGET_CYC);
	localparam logic [TW-1:0] TRIM_MAX = '1;
	localparam logic [TW-1:0] TSTEP    = TW'(sr_gate_pkg::TRIM_STEP);
	localparam logic [RW-1:0] R_NORM   = RW'(sr_gate_pkg::RATIO_NORM);
	localparam logic [RW-1:0] R_SUB    = RW'(sr_gate_pkg::RATIO_SUB);
	localparam logic [RW-1:0] R_STEP   = RW'(sr_gate_pkg::RATIO_STEP);
	localparam logic [PW-1:0] PCT      = PW'(sr_gate_pkg::PERCENT);
	localparam logic [DW-1:0] D_FAST   = DW'(DLY_FST);
	localparam logic [DW-1:0] D_SLOW   = DW'(DLY_SLW);

	typedef struct packed {
		sr_gate_pkg::gate_state_t state;
		logic          gate;
		logic          subh;
		logic [DW-1:0] dly;
		logic [CW-1:0] on_cnt;
		logic [CW-1:0] demag_cnt;
		logic [CW-1:0] demag_last;
		logic          demag_run;
		logic          ccm;
		logic [CW-1:0] pri_cnt;
		logic [CW-1:0] pri_prev;
		logic          pri_last;
		logic [RW-1:0] ratio;
		logic [TW-1:0] trim;
		logic [TW-1:0] dead_cnt;
		logic          dead_run;
	} ctrl_state_t;

	ctrl_state_t s;
	ctrl_state_t next_s;

	logic [PW-1:0] pred_prod;
	logic [PW-1:0] pred_lim;
	logic [DW-1:0] dly_target;
	logic          pri_rise;
	logic          pri_fall;
	logic          off_now;

	// =========================================================
	// synchronisers
	sense_if sense ();

	sense_sync #(
		.N(sr_gate_pkg::SENSE_N)
	) u_sync (
		.ref_clk(ref_clk),
		.reset  (reset),
		.raw    ({primary_on, turn_off_threshold, turn_on_threshold,
		          supply_lockout_level, supply_wake_level}),
		.sense  (sense.producer)
	);

	// =========================================================
	// prediction limit; divide by a constant, cheap enough here
	always_comb begin
		pred_prod = PW'(s.demag_last) * PW'(s.ratio);
		pred_lim  = pred_prod / PCT + PW'(s.trim);
		dly_target = slow_delay_sel ? D_SLOW : D_FAST;
		pri_rise  = sense.primary_on & ~s.pri_last;
		pri_fall  = ~sense.primary_on & s.pri_last;
		// threshold off is masked for trim cycles after turn-on
		off_now   = (sense.drain_off && ({{(TW){1'b0}}, s.on_cnt} >=
		             {{(CW){1'b0}}, s.trim}))
		            || sense.primary_on
		            || (s.on_cnt >= ON_LIM)
		            || (s.ccm && PW'(s.on_cnt) >= pred_lim);
	end

	// =========================================================
	// next state
	always_comb begin
		next_s          = s;
		next_s.pri_last = sense.primary_on;

		// primary on-time and sub-harmonic detection
		if (sense.primary_on && s.pri_cnt != CNT_MAX) begin
			next_s.pri_cnt = s.pri_cnt + 1'b1;
		end
		if (pri_fall) begin
			next_s.pri_prev = s.pri_cnt;
			next_s.pri_cnt  = '0;
			// no earlier pulse after reset, so nothing to compare against
			if (s.pri_prev != '0 &&
			    {1'b0, s.pri_cnt} >= {1'b0, s.pri_prev} + {1'b0, SUBH}) begin
				next_s.ratio = R_SUB;
				next_s.subh  = 1'b1;
			end else if (s.ratio < R_NORM) begin
				// climb back one step per switching cycle
				next_s.ratio = (R_NORM - s.ratio > R_STEP) ?
					s.ratio + R_STEP : R_NORM;
				next_s.subh  = 1'b0;
			end else begin
				next_s.subh  = 1'b0;
			end
		end

		// demagnetization timing
		if (s.demag_run) begin
			if (s.demag_cnt != CNT_MAX) begin
				next_s.demag_cnt = s.demag_cnt + 1'b1;
			end
			if (pri_rise) begin
				// cut short by primary turn-on: continuous conduction
				next_s.demag_last = s.demag_cnt;
				next_s.demag_run  = 1'b0;
				next_s.ccm        = 1'b1;
			end else if (s.state == sr_gate_pkg::ST_BLANK &&
			             sense.drain_off) begin
				next_s.demag_run = 1'b0;
				next_s.ccm       = 1'b0;
			end
		end

		// dead time from gate off to primary turn-on
		if (s.dead_run) begin
			if (s.dead_cnt != TRIM_MAX) begin
				next_s.dead_cnt = s.dead_cnt + 1'b1;
			end
			if (pri_rise) begin
				next_s.dead_run = 1'b0;
				if (s.dead_cnt > DEAD_TGT && s.trim != TRIM_MAX) begin
					next_s.trim = s.trim + TSTEP;
				end else if (s.dead_cnt < DEAD_TGT && s.trim != '0) begin
					next_s.trim = s.trim - TSTEP;
				end
			end else if (!s.demag_run) begin
				next_s.dead_run = 1'b0;
			end
		end

		case (s.state)
			sr_gate_pkg::ST_LOCKOUT: begin
				next_s.gate = 1'b0;
				if (sense.supply_wake_level) begin
					next_s.state = sr_gate_pkg::ST_IDLE;
				end
			end
			sr_gate_pkg::ST_IDLE: begin
				if (sense.drain_low && !sense.primary_on) begin
					next_s.state     = sr_gate_pkg::ST_DELAY;
					next_s.dly       = '0;
					next_s.demag_run = 1'b1;
					next_s.demag_cnt = '0;
				end
			end
			sr_gate_pkg::ST_DELAY: begin
				// a glitch that clears before the delay is ignored
				if (!sense.drain_low || sense.primary_on) begin
					next_s.state = sr_gate_pkg::ST_BLANK;
				end else if (s.dly + 1'b1 >= dly_target) begin
					next_s.state  = sr_gate_pkg::ST_ON;
					next_s.gate   = 1'b1;
					next_s.on_cnt = '0;
				end else begin
					next_s.dly = s.dly + 1'b1;
				end
			end
			sr_gate_pkg::ST_ON: begin
				next_s.on_cnt = s.on_cnt + 1'b1;
				if (off_now) begin
					next_s.gate     = 1'b0;
					next_s.state    = sr_gate_pkg::ST_BLANK;
					next_s.dead_run = 1'b1;
					next_s.dead_cnt = '0;
				end
			end
			sr_gate_pkg::ST_BLANK: begin
				if (!next_s.demag_run) begin
					next_s.state = sr_gate_pkg::ST_IDLE;
				end
			end
			default: begin
				next_s.state = sr_gate_pkg::ST_LOCKOUT;
				next_s.gate  = 1'b0;
			end
		endcase

		// lockout overrides the state, the gate, both timers and ccm; sub_harmonic and ratio keep updating, trim holds as dead_run is cleared
		if (sense.supply_lockout_level) begin
			next_s.state     = sr_gate_pkg::ST_LOCKOUT;
			next_s.gate      = 1'b0;
			next_s.demag_run = 1'b0;
			next_s.dead_run  = 1'b0;
			next_s.ccm       = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			s       <= '0;
			s.state <= sr_gate_pkg::ST_LOCKOUT;
			s.ratio <= R_NORM;
		end else begin
			s <= next_s;
		end
	end

	assign rectifier_switch = s.gate;
	assign sub_harmonic     = s.subh;
endmodule

// >>> sr_gate_props.sv
// checker for the rectifier gate timing block
// assumes it is bound onto sr_gate_ctrl and sees only its ports
`timescale 1ns/1ns
module sr_gate_props #(
	parameter int MAX_ON = 4000
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// comparators and select
	input wire logic supply_wake_level,
	input wire logic supply_lockout_level,
	input wire logic turn_on_threshold,
	input wire logic turn_off_threshold,
	input wire logic primary_on,
	input wire logic slow_delay_sel,
	// outputs
	input wire logic rectifier_switch,
	input wire logic sub_harmonic
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);
	logic        woke;
	logic [15:0] on_run;

	// =========================================================
	// helpers
	// woke is set early and cleared early, so it never lags the core
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			woke   <= 1'b0;
			on_run <= 16'h0;
		end else begin
			woke   <= (woke | supply_wake_level) & ~supply_lockout_level;
			on_run <= rectifier_switch ? on_run + 16'h1 : 16'h0;
		end
	end

	// =========================================================
	// properties
	sequence fast_req;
		!rectifier_switch && !slow_delay_sel && $rose(turn_on_threshold);
	endsequence
	sequence gate_rise;
		$rose(rectifier_switch);
	endsequence
	wake_first_a: assert property (
		rectifier_switch |-> $past(woke, 4)) else $error("gate before wake");
	lock_low_a: assert property (
		supply_lockout_level [*4] |-> !rectifier_switch) else $error("lockout");
	rise_cause_a: assert property (
		gate_rise |-> $past(turn_on_threshold, 3)) else $error("rise cause");
	on_delay_a: assert property (
		fast_req |-> !rectifier_switch [*8]) else $error("delay short");
	off_fast_a: assert property (
		turn_off_threshold [*8] |-> !rectifier_switch) else $error("off late");
	pri_off_a: assert property (
		primary_on [*4] |-> !rectifier_switch) else $error("on with primary");
	max_on_a: assert property (
		on_run <= MAX_ON) else $error("on-time over limit");
	sub_edge_a: assert property (
		$changed(sub_harmonic) |-> !primary_on && $past(primary_on, 4))
		else $error("sub flag moved off primary fall");
	cover_sub: cover property ($rose(sub_harmonic));
endmodule

bind sr_gate_ctrl sr_gate_props #(.MAX_ON(MAX_ON)) props_u (
	.ref_clk, .reset, .supply_wake_level, .supply_lockout_level,
	.turn_on_threshold, .turn_off_threshold, .primary_on,
	.slow_delay_sel, .rectifier_switch, .sub_harmonic
);

// >>> flyback_model.sv
// flyback secondary and primary switch seen through the drain comparators
// assumes the bench calls run_cycle; levels move on the falling edge
`timescale 1ns/1ns
module flyback_model (
	// clock and gate
	input  wire logic ref_clk,
	input  wire logic rectifier_switch,
	// comparator levels
	output logic      turn_on_threshold,
	output logic      turn_off_threshold,
	output logic      primary_on
);
	// =========================================================
	// one switching period
	initial begin
		turn_on_threshold = 1'b0;
		turn_off_threshold = 1'b1;
		primary_on = 1'b0;
	end
	// body diode only conducts while the gate is off
	task automatic run_cycle(input int demag, input int pri, input bit ccm);
		@(negedge ref_clk);
		turn_off_threshold = 1'b0;
		repeat (demag) begin
			turn_on_threshold = ~rectifier_switch;
			@(negedge ref_clk);
		end
		turn_on_threshold = 1'b0;
		primary_on = ccm;
		@(negedge ref_clk);
		turn_off_threshold = 1'b1;
		if (!ccm) begin
			repeat (100) @(negedge ref_clk);
			primary_on = 1'b1;
		end
		repeat (pri) @(negedge ref_clk);
		primary_on = 1'b0;
	endtask
endmodule

// >>> sr_gate_ctrl_tb.sv
// self-checking bench for the rectifier gate timing block
// assumes flyback_model on the drain side and the bound checker
`timescale 1ns/1ns
module sr_gate_ctrl_tb;
	localparam int MAX_ON = 500;
	logic ref_clk, reset, wake, lock, slow_sel;
	logic ton, toff, pri, gate, subh;
	int   n_mismatch, checks_done, a, rise_base;
	int   run = 0;
	int   last_on = 0;
	int   n_rise = 0;

	always #5 ref_clk = ~ref_clk;
	sr_gate_ctrl #(.MAX_ON(MAX_ON)) dut_u (
		.ref_clk(ref_clk), .reset(reset),
		.supply_wake_level(wake), .supply_lockout_level(lock),
		.turn_on_threshold(ton), .turn_off_threshold(toff),
		.primary_on(pri), .slow_delay_sel(slow_sel),
		.rectifier_switch(gate), .sub_harmonic(subh));
	flyback_model model_u (.ref_clk(ref_clk), .rectifier_switch(gate),
		.turn_on_threshold(ton), .turn_off_threshold(toff), .primary_on(pri));

	// =========================================================
	// gate on-time monitor
	always @(posedge ref_clk) begin
		if (gate === 1'b1) begin
			run <= run + 1;
		end else if (run != 0) begin
			last_on <= run;
			n_rise <= n_rise + 1;
			run <= 0;
		end
	end

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %0d seen %0d", what, exp, seen);
		end
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic do_reset(input logic w);
		reset = 1'b1;
		wake = w;
		lock = 1'b0;
		slow_sel = 1'b0;
		repeat (3) @(negedge ref_clk);
		reset = 1'b0;
		repeat (5) @(negedge ref_clk);
		rise_base = n_rise;
	endtask

	// =========================================================
	// scenarios
	task automatic s_wake;
		do_reset(1'b0);
		model_u.run_cycle(200, 60, 1'b0);
		check("gate in lockout", n_rise - rise_base, 0);
		wake = 1'b1;
		repeat (5) @(negedge ref_clk);
		model_u.run_cycle(200, 60, 1'b0);
		check("gate after wake", n_rise - rise_base, 1);
		check("dcm window", last_on inside {[180:200]}, 1);
		a = last_on;
		slow_sel = 1'b1;
		model_u.run_cycle(200, 60, 1'b0);
		check("slow delay", (a - last_on) inside {[12:14]}, 1);
	endtask
	task automatic s_ccm;
		do_reset(1'b1);
		repeat (2) model_u.run_cycle(300, 60, 1'b1);
		check("ccm on", last_on inside {[180:215]}, 1);
		a = last_on;
		repeat (3) model_u.run_cycle(300, 60, 1'b1);
		check("dead trim", last_on > a, 1);
	endtask
	// continues from s_ccm state: primary on-time jumps by 60 cycles
	task automatic s_sub;
		model_u.run_cycle(300, 120, 1'b1);
		for (a = 0; a < 20 && subh !== 1'b1; a++)
			@(negedge ref_clk);
		check("sub flag", subh, 1'b1);
		if (a == 20)
			final_report;
		model_u.run_cycle(300, 120, 1'b1);
		check("sub on", last_on inside {[30:70]}, 1);
		a = last_on;
		model_u.run_cycle(300, 120, 1'b1);
		check("ratio climb", last_on > a, 1);
		check("sub clear", subh, 1'b0);
	endtask
	task automatic s_max;
		do_reset(1'b1);
		model_u.run_cycle(800, 60, 1'b0);
		check("max on", last_on inside {[MAX_ON-1:MAX_ON]}, 1);
		check("blank refuse", n_rise - rise_base, 1);
	endtask
	task automatic s_lock;
		do_reset(1'b1);
		fork
			model_u.run_cycle(300, 60, 1'b0);
			begin
				repeat (100) @(negedge ref_clk);
				check("gate up", gate, 1'b1);
				lock = 1'b1;
				repeat (4) @(negedge ref_clk);
				check("lockout gate", gate, 1'b0);
			end
		join
		check("lockout refuse", n_rise - rise_base, 1);
	endtask

	initial begin
		ref_clk = 1'b0;
		n_mismatch = 0;
		checks_done = 0;
		do_reset(1'b0);
		s_wake;
		s_ccm;
		s_sub;
		s_max;
		s_lock;
		final_report;
	end
endmodule
